// [rtl/usd_std_request.sv]
// usd_std_request: endpoint-zero standard request decoder with descriptor
// source. assumes the serial engine hands over checked setup packets and IN
// tokens as one-cycle pulses, all synchronous to clk_sys.
//
// Operation
// - clear halt on bulk-in, bulk-out, interrupt-in endpoint
// - set halt on bulk-in or bulk-out endpoint
// - interrupt-in set halt uses high index byte
// - device set feature enables remote wakeup
// - device clear feature disables remote wakeup
// - set configuration one configures, zero unconfigures
// - device descriptor, eighteen bytes, ids from parameters
// - never return more than requested length
// - configuration set of 27h bytes
// - interface class byte chosen by control register
// - three endpoint descriptors with fixed sizes
// - string zero lists one language id
// - string one, manufacturer, sixteen bytes
// - string two, product name, 1Eh bytes
// - string three, serial number, 0Ah bytes
`timescale 1ns/100ps

module usd_std_request #(
  parameter logic [15:0] VENDOR_ID  = 16'h1234,  // arbitrary value
  parameter logic [15:0] PRODUCT_ID = 16'h5678,  // arbitrary value
  parameter logic [15:0] RELEASE_ID = 16'h0100   // arbitrary value
) (
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // setup stage from the serial engine
  input  wire logic                setup_valid,
  input  wire usd_pkg::usd_setup_s setup,
  output logic                     req_ack,
  output logic                     req_stall,
  // in data stage
  input  wire logic                in_token,
  output logic                     tx_valid,
  output usd_pkg::usd_tx_s         tx,
  input  wire logic                tx_ready,
  output logic                     tx_zlp,
  // device state
  output logic [2:0]               ep_halt,
  output logic                     remote_wake_en,
  output logic                     configured
);

  // ==========================================================================
  // helpers
  function automatic logic [7:0] rom_byte(input logic [6:0] adr);
    rom_byte = usd_pkg::ROM_ALL[(usd_pkg::ROM_LEN - 1 - int'(adr)) * 8 +: 8];
  endfunction

  // one-hot endpoint select: bulk-in, bulk-out, interrupt-in
  function automatic logic [2:0] ep_decode(input logic [7:0] idx);
    ep_decode = {idx == usd_pkg::EP_INTR_IN, idx == usd_pkg::EP_BULK_OUT,
                 idx == usd_pkg::EP_BULK_IN};
  endfunction

  // ==========================================================================
  // setup decode
  wire logic       len_zero   = (setup.len_l == usd_pkg::ZERO8)
                              && (setup.len_h == usd_pkg::ZERO8);
  wire logic       val_zero   = (setup.value_l == usd_pkg::ZERO8)
                              && (setup.value_h == usd_pkg::ZERO8);
  wire logic       idx_zero   = (setup.index_l == usd_pkg::ZERO8)
                              && (setup.index_h == usd_pkg::ZERO8);
  wire logic       idx_lang   = (setup.index_l == usd_pkg::LANG_L)
                              && (setup.index_h == usd_pkg::LANG_H);
  wire logic [2:0] ep_lo      = ep_decode(setup.index_l);
  wire logic       ep_plain   = setup.index_h == usd_pkg::ZERO8;

  wire logic is_ep_clr = (setup.bm_req == usd_pkg::RT_EP_OUT)
                      && (setup.b_req == usd_pkg::RQ_CLR_FEAT)
                      && val_zero && len_zero && ep_plain
                      && (ep_lo != 3'h0);

  // interrupt-in halt form: endpoint in the high index byte
  wire logic set_ep3   = (setup.index_l == usd_pkg::ZERO8)
                      && (setup.index_h == usd_pkg::EP_INTR_IN);
  wire logic is_ep_set = (setup.bm_req == usd_pkg::RT_EP_OUT)
                      && (setup.b_req == usd_pkg::RQ_SET_FEAT)
                      && val_zero && len_zero
                      && ((ep_plain && (ep_lo[1:0] != 2'h0)) || set_ep3);
  // halt bits to set, one per endpoint
  wire logic [2:0] set_mask = {set_ep3, ep_plain ? ep_lo[1:0] : 2'h0};

  wire logic is_set_if = (setup.bm_req == usd_pkg::RT_IF_OUT)
                      && (setup.b_req == usd_pkg::RQ_SET_IF)
                      && val_zero && idx_zero && len_zero;

  wire logic dev_feat  = (setup.bm_req == usd_pkg::RT_DEV_OUT)
                      && (setup.value_l == usd_pkg::FS_WAKEUP)
                      && (setup.value_h == usd_pkg::ZERO8)
                      && idx_zero && len_zero;
  wire logic is_wk_set = dev_feat && (setup.b_req == usd_pkg::RQ_SET_FEAT);
  wire logic is_wk_clr = dev_feat && (setup.b_req == usd_pkg::RQ_CLR_FEAT);

  // only the single configuration or none
  wire logic cfg_val   = (setup.value_l == usd_pkg::CFG_ONE)
                      || (setup.value_l == usd_pkg::ZERO8);
  wire logic is_set_cf = (setup.bm_req == usd_pkg::RT_DEV_OUT)
                      && (setup.b_req == usd_pkg::RQ_SET_CFG)
                      && cfg_val && (setup.value_h == usd_pkg::ZERO8)
                      && idx_zero && len_zero;

  wire logic get_desc  = (setup.bm_req == usd_pkg::RT_DEV_IN)
                      && (setup.b_req == usd_pkg::RQ_GET_DESC);
  wire logic d_dev     = get_desc && (setup.value_h == usd_pkg::DT_DEVICE)
                      && (setup.value_l == usd_pkg::ZERO8) && idx_zero;
  wire logic d_cfg     = get_desc && (setup.value_h == usd_pkg::DT_CONFIG)
                      && (setup.value_l == usd_pkg::ZERO8) && idx_zero;
  wire logic d_str     = get_desc && (setup.value_h == usd_pkg::DT_STRING);
  wire logic d_s0      = d_str && (setup.value_l == 8'h00) && idx_zero;
  wire logic d_s1      = d_str && (setup.value_l == 8'h01) && idx_lang;
  wire logic d_s2      = d_str && (setup.value_l == 8'h02) && idx_lang;
  wire logic d_s3      = d_str && (setup.value_l == 8'h03) && idx_lang;
  wire logic is_desc   = d_dev | d_cfg | d_s0 | d_s1 | d_s2 | d_s3;

  wire logic no_data   = is_ep_clr | is_ep_set | is_set_if
                      | is_wk_set | is_wk_clr | is_set_cf;
  wire logic accepted  = no_data | is_desc;

  // table window of the selected descriptor
  wire logic [6:0] sel_base =
      d_dev ? usd_pkg::DEV_BASE : d_cfg ? usd_pkg::CFG_BASE :
      d_s0  ? usd_pkg::S0_BASE  : d_s1  ? usd_pkg::S1_BASE  :
      d_s2  ? usd_pkg::S2_BASE  : usd_pkg::S3_BASE;
  wire logic [6:0] sel_len =
      d_dev ? usd_pkg::DEV_LEN : d_cfg ? usd_pkg::CFG_LEN :
      d_s0  ? usd_pkg::S0_LEN  : d_s1  ? usd_pkg::S1_LEN  :
      d_s2  ? usd_pkg::S2_LEN  : usd_pkg::S3_LEN;

  // the host length cuts the descriptor short
  wire logic [15:0] req_len  = {setup.len_h, setup.len_l};
  wire logic        len_cut  = req_len < {9'h000, sel_len};
  wire logic [6:0]  send_len = len_cut ? req_len[6:0] : sel_len;
  wire logic        need_zlp = !len_cut && (req_len != {9'h000, sel_len});

  // ==========================================================================
  // registers
  usd_pkg::usd_state_e state_q, state_d;
  logic [6:0] ptr_q;
  logic [6:0] remain_q;
  logic [3:0] pkt_cnt_q;
  logic       zlp_due_q;
  logic [2:0] halt_q;
  logic       wake_q;
  logic       cfg_q;
  logic       class_sel_q;
  logic [7:0] tx_data_q;
  logic       ack_q;
  logic       stall_q;
  logic       zlp_q;

  // bytes patched over the table
  function automatic logic [7:0] desc_byte(input logic [6:0] adr,
                                           input logic       cls);
    logic [47:0] ids;
    ids = {VENDOR_ID[7:0], VENDOR_ID[15:8], PRODUCT_ID[7:0], PRODUCT_ID[15:8],
           RELEASE_ID[7:0], RELEASE_ID[15:8]};
    if (adr >= usd_pkg::ID_FIRST && adr <= usd_pkg::ID_LAST)
      desc_byte = ids[(5 - int'(adr - usd_pkg::ID_FIRST)) * 8 +: 8];
    // past the table end: keeps the idle data byte defined
    else if (int'(adr) >= usd_pkg::ROM_LEN)
      desc_byte = usd_pkg::ZERO8;
    else if (adr == usd_pkg::CLS_ADR || adr == usd_pkg::SUB_ADR)
      desc_byte = cls ? usd_pkg::CLASS_NEW : usd_pkg::CLASS_OLD;
    else
      desc_byte = rom_byte(adr);
  endfunction

  // ==========================================================================
  // in data stage
  wire logic       tx_fire   = tx_valid && tx_ready;
  // packet closes on its last byte or on the eighth
  wire logic       pkt_end   = (remain_q == 7'h01)
                            || (pkt_cnt_q == usd_pkg::PKT_MAX - 4'h1);
  wire logic [6:0] ptr_nx    = ptr_q + 7'h01;
  wire logic       start_pkt = (state_q == usd_pkg::USD_WAIT) && in_token
                            && (remain_q != 7'h00);
  wire logic       send_zlp  = (state_q == usd_pkg::USD_WAIT) && in_token
                            && (remain_q == 7'h00);

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      usd_pkg::USD_IDLE:
        if (setup_valid && is_desc)
          state_d = usd_pkg::USD_WAIT;
      usd_pkg::USD_WAIT:
        if (setup_valid)
          state_d = is_desc ? usd_pkg::USD_WAIT : usd_pkg::USD_IDLE;
        else if (start_pkt)
          state_d = usd_pkg::USD_SEND;
        else if (send_zlp)
          state_d = usd_pkg::USD_IDLE;
      usd_pkg::USD_SEND:
        if (setup_valid)
          state_d = is_desc ? usd_pkg::USD_WAIT : usd_pkg::USD_IDLE;
        else if (tx_fire && pkt_end)
          // a full packet at the end still owes a zero-length one if shorter than requested
          state_d = (remain_q == 7'h01 && !zlp_due_q) ? usd_pkg::USD_IDLE
                                                      : usd_pkg::USD_WAIT;
      default:
        state_d = usd_pkg::USD_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      state_q <= usd_pkg::USD_IDLE;
    else
      state_q <= state_d;
  end

  // pointer, remaining count and packet byte count
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ptr_q     <= 7'h00;
      remain_q  <= 7'h00;
      pkt_cnt_q <= 4'h0;
      zlp_due_q <= 1'b0;
      tx_data_q <= 8'h00;
    end
    else if (setup_valid && is_desc)
    begin
      ptr_q     <= sel_base;
      remain_q  <= send_len;
      pkt_cnt_q <= 4'h0;
      zlp_due_q <= need_zlp && (send_len[2:0] == 3'h0);
    end
    // any other setup abandons the data stage
    else if (setup_valid)
    begin
      remain_q  <= 7'h00;
      zlp_due_q <= 1'b0;
    end
    else if (start_pkt)
    begin
      pkt_cnt_q <= 4'h0;
      tx_data_q <= desc_byte(ptr_q, class_sel_q);
    end
    else if (tx_fire)
    begin
      ptr_q     <= ptr_nx;
      remain_q  <= remain_q - 7'h01;
      pkt_cnt_q <= pkt_cnt_q + 4'h1;
      tx_data_q <= desc_byte(ptr_nx, class_sel_q);
    end
  end

  // ==========================================================================
  // request effects
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      halt_q <= 3'h0;
      wake_q <= 1'b0;
      cfg_q  <= 1'b0;
    end
    else if (setup_valid)
    begin
      if (is_ep_clr)
        halt_q <= halt_q & ~ep_lo;
      else if (is_ep_set)
        halt_q <= halt_q | set_mask;
      if (is_wk_set)
        wake_q <= 1'b1;
      else if (is_wk_clr)
        wake_q <= 1'b0;
      if (is_set_cf)
        cfg_q <= setup.value_l == usd_pkg::CFG_ONE;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_q   <= 1'b0;
      stall_q <= 1'b0;
      zlp_q   <= 1'b0;
    end
    else
    begin
      ack_q   <= setup_valid && accepted;
      stall_q <= setup_valid && !accepted;
      zlp_q   <= send_zlp && !setup_valid;
    end
  end

  // ==========================================================================
  // apb slave, zero wait states
  wire logic        apb_acc  = psel && penable;
  wire logic        hit_ctrl = paddr == usd_pkg::REG_CTRL;
  wire logic        hit_stat = paddr == usd_pkg::REG_STATUS;
  wire logic        apb_err  = !(hit_ctrl || hit_stat);
  wire logic [31:0] rd_ctrl  = {31'h0000_0000, class_sel_q};
  wire logic [31:0] rd_stat  = {22'h00_0000, state_q, remain_q == 7'h00,
                                wake_q, cfg_q, halt_q, 1'b0};

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      class_sel_q <= usd_pkg::CTRL_CLASS_RST;
    else if (apb_acc && pwrite && hit_ctrl)
      class_sel_q <= pwdata[usd_pkg::CTRL_CLASS];
  end

  assign pready  = 1'b1;
  assign pslverr = apb_acc && apb_err;

  // reads return zero outside a selected read
  assign prdata  = (psel && !pwrite && hit_ctrl) ? rd_ctrl :
                   (psel && !pwrite && hit_stat) ? rd_stat : 32'h0000_0000;

  // ==========================================================================
  // outputs
  assign req_ack        = ack_q;
  assign req_stall      = stall_q;
  assign tx_zlp         = zlp_q;
  assign tx_valid       = state_q == usd_pkg::USD_SEND;
  assign tx.data        = tx_data_q;
  assign tx.last        = tx_valid && pkt_end;
  assign ep_halt        = halt_q;
  assign remote_wake_en = wake_q;
  assign configured     = cfg_q;

endmodule // usd_std_request

// [rtl/usd_pkg.sv]
// usd_pkg: constants, layouts and descriptor tables of the endpoint-zero
// standard request decoder. assumes byte 0 of every table is sent first.
package usd_pkg;

  // ==========================================================================
  // setup packet layout
  typedef struct packed {
    logic [7:0] bm_req;
    logic [7:0] b_req;
    logic [7:0] value_l;
    logic [7:0] value_h;
    logic [7:0] index_l;
    logic [7:0] index_h;
    logic [7:0] len_l;
    logic [7:0] len_h;
  } usd_setup_s;

  // packet byte towards the serial engine
  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } usd_tx_s;

  // ==========================================================================
  // request encodings
  localparam logic [7:0] RT_DEV_OUT  = 8'h00;
  localparam logic [7:0] RT_IF_OUT   = 8'h01;
  localparam logic [7:0] RT_EP_OUT   = 8'h02;
  localparam logic [7:0] RT_DEV_IN   = 8'h80;
  localparam logic [7:0] RQ_CLR_FEAT = 8'h01;
  localparam logic [7:0] RQ_SET_FEAT = 8'h03;
  localparam logic [7:0] RQ_GET_DESC = 8'h06;
  localparam logic [7:0] RQ_SET_CFG  = 8'h09;
  localparam logic [7:0] RQ_SET_IF   = 8'h0b;
  localparam logic [7:0] FS_WAKEUP   = 8'h01;
  localparam logic [7:0] EP_BULK_IN  = 8'h81;
  localparam logic [7:0] EP_BULK_OUT = 8'h02;
  localparam logic [7:0] EP_INTR_IN  = 8'h83;
  localparam logic [7:0] DT_DEVICE   = 8'h01;
  localparam logic [7:0] DT_CONFIG   = 8'h02;
  localparam logic [7:0] DT_STRING   = 8'h03;
  localparam logic [7:0] LANG_L      = 8'h09;
  localparam logic [7:0] LANG_H      = 8'h04;
  localparam logic [7:0] CFG_ONE     = 8'h01;
  localparam logic [7:0] ZERO8       = 8'h00;
  localparam logic [7:0] CLASS_NEW   = 8'hff;
  localparam logic [7:0] CLASS_OLD   = 8'h00;
  localparam logic [3:0] PKT_MAX     = 4'h8;

  // ==========================================================================
  // descriptor table: byte offsets and lengths
  localparam logic [6:0] DEV_BASE = 7'h00;
  localparam logic [6:0] DEV_LEN  = 7'h12;
  localparam logic [6:0] CFG_BASE = 7'h12;
  localparam logic [6:0] CFG_LEN  = 7'h27;
  localparam logic [6:0] S0_BASE  = 7'h39;
  localparam logic [6:0] S0_LEN   = 7'h04;
  localparam logic [6:0] S1_BASE  = 7'h3d;
  localparam logic [6:0] S1_LEN   = 7'h10;
  localparam logic [6:0] S2_BASE  = 7'h4d;
  localparam logic [6:0] S2_LEN   = 7'h1e;
  localparam logic [6:0] S3_BASE  = 7'h6b;
  localparam logic [6:0] S3_LEN   = 7'h0a;
  localparam int         ROM_LEN  = 117;
  // overridden bytes: id words, interface class and protocol
  localparam logic [6:0] ID_FIRST = 7'h08;
  localparam logic [6:0] ID_LAST  = 7'h0d;
  localparam logic [6:0] CLS_ADR  = 7'h20;
  localparam logic [6:0] SUB_ADR  = 7'h22;

  localparam logic [143:0] ROM_DEV =
    144'h1201_1001_0000_0008_0000_0000_0000_0102_0301;
  localparam logic [311:0] ROM_CFG =
    312'h09_0227_0001_0100_a050_0904_0000_0300_0000_0007_0581_0240_0000_0705_0202_4000_0007_0583_0308_0001;
  localparam logic [31:0]  ROM_S0  = 32'h0403_0409;
  localparam logic [127:0] ROM_S1  = 128'h1003_5200_4500_4100_4c00_5400_4500_4b00;
  localparam logic [239:0] ROM_S2  =
    240'h1e03_5500_5300_4200_2000_3100_3000_2f00_3100_3000_3000_2000_4c00_4100_4e00;
  localparam logic [79:0]  ROM_S3  = 80'h0a03_3000_3000_3000_3100;
  localparam logic [ROM_LEN*8-1:0] ROM_ALL =
    {ROM_DEV, ROM_CFG, ROM_S0, ROM_S1, ROM_S2, ROM_S3};

  // ==========================================================================
  // apb register map
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam int         CTRL_CLASS = 0;
  localparam logic       CTRL_CLASS_RST = 1'b1;

  typedef enum logic [2:0] {
    USD_IDLE = 3'h1,
    USD_WAIT = 3'h2,
    USD_SEND = 3'h4
  } usd_state_e;

endpackage

// [tb/usd_std_request_chk.sv]
// usd_std_request_chk: port-level assertions of the request decoder.
// assumes binding onto usd_std_request, one clock, async active-low reset.
`timescale 1ns/100ps

module usd_std_request_chk (
  input wire logic                clk_sys,
  input wire logic                rst_n,
  input wire logic                setup_valid,
  input wire usd_pkg::usd_setup_s setup,
  input wire logic                req_ack,
  input wire logic                req_stall,
  input wire logic                tx_valid,
  input wire usd_pkg::usd_tx_s    tx,
  input wire logic                tx_ready,
  input wire logic                tx_zlp,
  input wire logic [2:0]          ep_halt,
  input wire logic                remote_wake_en,
  input wire logic                configured
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ==========================================================================
  // request forms
  wire logic wk_on  = setup_valid && setup == 64'h0003_0100_0000_0000;
  wire logic wk_off = setup_valid && setup == 64'h0001_0100_0000_0000;
  wire logic cf_on  = setup_valid && setup == 64'h0009_0100_0000_0000;
  wire logic cf_off = setup_valid && setup == 64'h0009_0000_0000_0000;
  wire logic clr_bi = setup_valid && setup == 64'h0201_0000_8100_0000;
  wire logic set_bo = setup_valid && setup == 64'h0203_0000_0200_0000;
  wire logic set_ii = setup_valid && setup == 64'h0203_0000_0083_0000;
  wire logic bad_ii = setup_valid && setup == 64'h0203_0000_8300_0000;
  // ==========================================================================
  // assertions
  chk_resp_one: assert property (setup_valid |=> req_ack != req_stall)
    else $error("setup answer missing or doubled");
  chk_resp_none: assert property (!setup_valid |=> !req_ack && !req_stall)
    else $error("answer without setup");
  chk_wake_on: assert property (wk_on |=> remote_wake_en && req_ack)
    else $error("remote wakeup not enabled");
  chk_wake_off: assert property (wk_off |=> !remote_wake_en && req_ack)
    else $error("remote wakeup not disabled");
  chk_cfg_on: assert property (cf_on |=> configured && req_ack)
    else $error("configuration one not entered");
  chk_cfg_off: assert property (cf_off |=> !configured && req_ack)
    else $error("unconfigured state not entered");
  chk_halt_clr: assert property (clr_bi |=> !ep_halt[0] && $stable(ep_halt[2:1]))
    else $error("bulk in halt not cleared");
  chk_halt_out: assert property (set_bo |=> ep_halt[1] && req_ack)
    else $error("bulk out halt not set");
  chk_halt_int: assert property (set_ii |=> ep_halt[2] && req_ack)
    else $error("interrupt in halt not set");
  chk_int_form: assert property (bad_ii |=> req_stall && $stable(ep_halt))
    else $error("low index form of interrupt halt accepted");
  chk_tx_hold: assert property (tx_valid && !tx_ready && !setup_valid
    |=> tx_valid && $stable(tx))
    else $error("packet byte dropped before acceptance");
  cov_stall: cover property (setup_valid ##1 req_stall);
  cov_last: cover property (tx_valid && tx_ready && tx.last);
  cov_zlp: cover property (tx_zlp);
endmodule // usd_std_request_chk

bind usd_std_request usd_std_request_chk u_chk (.clk_sys, .rst_n, .setup_valid, .setup,
  .req_ack, .req_stall, .tx_valid, .tx, .tx_ready, .tx_zlp, .ep_halt, .remote_wake_en,
  .configured);

// [tb/usd_host_model.sv]
// usd_host_model: host side of endpoint zero, issues setups and in tokens.
// assumes the testbench calls its tasks; drives only after rising edges.
`timescale 1ns/100ps

module usd_host_model (
  input  wire logic                clk_sys,
  output logic                     setup_valid,
  output usd_pkg::usd_setup_s      setup,
  input  wire logic                req_ack,
  input  wire logic                req_stall,
  output logic                     in_token,
  input  wire logic                tx_valid,
  input  wire usd_pkg::usd_tx_s    tx,
  output logic                     tx_ready,
  input  wire logic                tx_zlp
);
  logic [7:0] got [$];
  logic       slow, hung, bad, zlp;
  initial
  begin
    setup_valid = 1'b0;
    setup = '0;
    in_token = 1'b0;
    tx_ready = 1'b0;
    slow = 1'b0;
    hung = 1'b0;
  end
  // ==========================================================================
  // setup stage, answer sampled after the taking edge
  task automatic setup_req(input usd_pkg::usd_setup_s s, output logic a);
    @(posedge clk_sys);
    setup_valid <= 1'b1;
    setup       <= s;
    @(posedge clk_sys);
    setup_valid <= 1'b0;
    setup       <= ~s;
    #1;
    a = req_ack;
  endtask
  // ==========================================================================
  // in data stage, one token per packet
  task automatic read_desc(input int len);
    int k, pk;
    got.delete();
    bad = 1'b0;
    zlp = 1'b0;
    forever
    begin
      @(posedge clk_sys);
      in_token <= 1'b1;
      tx_ready <= !slow;
      @(posedge clk_sys);
      in_token <= 1'b0;
      pk = 0;
      for (k = 0; k < 40; k++)
      begin
        @(posedge clk_sys);
        if (tx_zlp === 1'b1)
        begin
          zlp = 1'b1;
          break;
        end
        if (tx_valid === 1'b1 && tx_ready)
        begin
          got.push_back(tx.data);
          pk++;
          if (tx.last === 1'b1) break;
        end
        tx_ready <= slow ? !tx_ready : 1'b1; // stall half the cycles when slow
      end
      if (k == 40) hung = 1'b1;
      if (pk > 8) bad = 1'b1;
      if (hung || zlp || pk < 8 || got.size() >= len) break;
    end
  endtask
endmodule // usd_host_model

// [tb/usd_standard_request_decoder_test.sv]
// usd_standard_request_decoder_test: self-checking bench of the decoder.
// assumes usd_pkg, the decoder, its checker and the host model compiled first.
`timescale 1ns/100ps
`define chk(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end

module usd_standard_request_decoder_test;
  localparam logic [15:0] VEND = 16'h1234; // arbitrary value
  localparam logic [15:0] PROD = 16'h5678; // arbitrary value
  localparam logic [15:0] REL  = 16'h0100; // arbitrary value
  localparam logic [63:0] CS [15] = '{64'h0203_0000_8100_0000, 64'h0203_0000_0200_0000,
    64'h0203_0000_8300_0000, 64'h0203_0000_0083_0000, 64'h0201_0000_8100_0000,
    64'h0201_0000_0200_0000, 64'h0201_0000_8300_0000, 64'h0003_0100_0000_0000,
    64'h0001_0100_0000_0000, 64'h0009_0100_0000_0000, 64'h0009_0000_0000_0000,
    64'h010b_0000_0000_0000, 64'hc005_0000_0000_0000, 64'h010b_0100_0000_0000,
    64'h8006_0103_0000_4000};
  localparam logic [5:0] CX [15] = '{6'h24, 6'h2c, 6'h0c, 6'h3c, 6'h38, 6'h30, 6'h20,
    6'h22, 6'h20, 6'h21, 6'h20, 6'h20, 6'h00, 6'h00, 6'h00};
  logic               clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata;
  logic               setup_valid, req_ack, req_stall, in_token, tx_valid, tx_ready;
  logic               tx_zlp, remote_wake_en, configured;
  logic [2:0]         ep_halt;
  usd_pkg::usd_setup_s setup;
  usd_pkg::usd_tx_s   tx;
  int                 n_mismatch, comparisons;

  usd_std_request #(.VENDOR_ID(VEND), .PRODUCT_ID(PROD), .RELEASE_ID(REL)) DUT (
    .clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .setup_valid, .setup, .req_ack, .req_stall, .in_token, .tx_valid, .tx,
    .tx_ready, .tx_zlp, .ep_halt, .remote_wake_en, .configured);
  usd_host_model host (.clk_sys, .setup_valid, .setup, .req_ack, .req_stall, .in_token,
    .tx_valid, .tx, .tx_ready, .tx_zlp);

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // ==========================================================================
  // shared tasks
  task automatic wrap_up();
    $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (k = 0; k < 20; k++)
    begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    if (k == 20)
    begin
      n_mismatch++;
      wrap_up();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [7:0] exp_b(input int k, input logic cls);
    logic [47:0] ids;
    ids = {REL, PROD, VEND};
    if (k >= 8 && k <= 13) return ids[(k-8)*8 +: 8];
    if (k == usd_pkg::CLS_ADR || k == usd_pkg::SUB_ADR) return cls ? 8'hff : 8'h00;
    return usd_pkg::ROM_ALL[(usd_pkg::ROM_LEN-1-k)*8 +: 8];
  endfunction
  task automatic t_desc(input logic [31:0] q, input int len, base, dlen, input logic cls);
    logic a;
    int   n;
    host.setup_req({16'h8006, q, len[7:0], len[15:8]}, a);
    `chk(a, 1'b1)
    host.read_desc(len);
    if (host.hung)
    begin
      n_mismatch++;
      wrap_up();
    end
    n = (len < dlen) ? len : dlen;
    `chk(host.got.size(), n)
    `chk(host.bad, 1'b0)
    `chk(host.zlp, (n < len && n % 8 == 0))
    for (int i = 0; i < host.got.size() && i < n; i++)
      `chk(host.got[i], exp_b(base + i, cls))
    $display("test descriptor %h done", q);
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_regs();
    logic [31:0] r;
    logic        e;
    apb(1'b0, usd_pkg::REG_CTRL, 32'h0000_0000, r, e);
    `chk(r, 32'h0000_0001)
    apb(1'b1, usd_pkg::REG_STATUS, 32'hffff_ffff, r, e);
    apb(1'b0, usd_pkg::REG_STATUS, 32'h0000_0000, r, e);
    `chk(r, 32'h0000_00c0)
    apb(1'b0, 8'h08, 32'h0000_0000, r, e);
    `chk({e, r}, 33'h1_0000_0000)
    $display("test regs done");
  endtask
  task automatic t_ctrl();
    logic a;
    for (int i = 0; i < 15; i++)
    begin
      host.setup_req(CS[i], a);
      `chk({a, ep_halt, remote_wake_en, configured}, CX[i])
    end
    $display("test control requests done");
  endtask
  task automatic t_descs();
    logic [31:0] r;
    logic        e;
    t_desc(32'h0001_0000, 64, 'h00, 18, 1'b1);
    `chk({host.got[0], host.got[7], host.got[17]}, 24'h1208_01)
    t_desc(32'h0001_0000, 8, 'h00, 18, 1'b1);
    host.slow = 1'b1;
    t_desc(32'h0002_0000, 255, 'h12, 39, 1'b1);
    `chk({host.got[2], host.got[7], host.got[8], host.got[13]}, 32'h27a0_5003)
    `chk({host.got[22], host.got[29], host.got[36], host.got[38]}, 32'h4040_0801)
    t_desc(32'h0003_0000, 64, 'h39, 4, 1'b1);
    t_desc(32'h0103_0904, 64, 'h3d, 16, 1'b1);
    t_desc(32'h0203_0904, 30, 'h4d, 30, 1'b1);
    t_desc(32'h0303_0904, 5, 'h6b, 10, 1'b1);
    apb(1'b1, usd_pkg::REG_CTRL, 32'h0000_0000, r, e);
    host.slow = 1'b0;
    t_desc(32'h0002_0000, 35, 'h12, 39, 1'b0);
  endtask

  initial
  begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    n_mismatch = 0;
    comparisons = 0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_regs();
    t_ctrl();
    t_descs();
    wrap_up();
  end
endmodule // usd_standard_request_decoder_test
